// ### hw/pco_pkg.sv
package pco_pkg;
	// ----------------------------------------------------------------
	// Register map of the device end.
	// ----------------------------------------------------------------
	localparam logic [7:0] PCO_ADDR_TRIG = 8'h57;
	localparam logic [7:0] PCO_ADDR_OVR = 8'h58;
	localparam logic [7:0] PCO_ADDR_TRIM = 8'h59;
	localparam logic [7:0] PCO_ADDR_PRST = 8'h5C;
	localparam logic [7:0] PCO_ADDR_CAL = 8'h5D;
	localparam logic [7:0] PCO_ADDR_STAT = 8'h5E;

	// Reset values.
	localparam logic [7:0] PCO_RST_TRIG = 8'h00;
	localparam logic [7:0] PCO_RST_OVR = 8'h00;
	localparam logic [6:0] PCO_RST_TRIM = 7'h00;

	// Writable bits of each register; all other bits are reserved and zero.
	localparam logic [7:0] PCO_MASK_TRIG = 8'h87;
	localparam logic [7:0] PCO_MASK_OVR = 8'hBF;
	localparam logic [7:0] PCO_MASK_TRIM = 8'h7F;
	localparam logic [7:0] PCO_MASK_PRST = 8'h01;
	localparam logic [7:0] PCO_MASK_CAL = 8'h01;

	// Field positions.
	localparam int PCO_TRIG_EN_BIT = 7;
	localparam int PCO_OVR_EN_BIT = 7;
	localparam int PCO_OVR_REFSE_BIT = 1;
	localparam int PCO_OVR_PLLEN_BIT = 0;

	// Trigger output mode codes.
	localparam logic [2:0] PCO_TRIG_UI16 = 3'h0;
	localparam logic [2:0] PCO_TRIG_UI32 = 3'h1;
	localparam logic [2:0] PCO_TRIG_UI64 = 3'h2;
	localparam logic [2:0] PCO_TRIG_TSTAMP = 3'h3;

	// Half periods of the serializer clocks, in unit intervals.
	localparam logic [5:0] PCO_HALF_UI16 = 6'h08;
	localparam logic [5:0] PCO_HALF_UI32 = 6'h10;
	localparam logic [5:0] PCO_HALF_UI64 = 6'h20;

	// Calibration settling time per trim step.
	localparam int PCO_CLK_PERIOD_PS = 8000;
	localparam int PCO_CAL_SETTLE_NS = 800;
	localparam int PCO_CAL_SETTLE_CYC =
		(PCO_CAL_SETTLE_NS * 1000 + PCO_CLK_PERIOD_PS - 1) / PCO_CLK_PERIOD_PS;

	// Calibration engine states.
	typedef enum logic [3:0] {
		PCO_CAL_IDLE = 4'b0001,
		PCO_CAL_SETTLE = 4'b0010,
		PCO_CAL_DECIDE = 4'b0100,
		PCO_CAL_DONE = 4'b1000
	} pco_cal_state_t;
endpackage

// ### hw/pco_link_if.sv
`timescale 1ns/1ps
interface pco_link_if (
	input wire logic mclk
);
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;

	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// ### hw/pco_device.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
//Contract
// - Codes 0-2 give 16/32/64 UI clocks.
// - Code 3 resamples timestamp; 4-7 reserved.
// - Host changes mode only while output disabled.
// - Serializer clocks stop during serializer reinit.
// - Override off: pins drive PLL controls.
// - Override on: register fields drive PLL controls.
// - Second output: off, or reference /1 /2 /4.
// - First output: off, or reference /1 /2 /4.
// - Override off: mode fields ignored, pins decide.
// - Second output needs first output running.
// - Override reference bit selects single-ended input.
// - Override PLL enable bit turns PLL on.
// - Seven-bit trim, software or calibration written.
// - Trim readable and restorable after calibration.
// - Host avoids trim access during calibration.
// - Host writes reserved bits as zero.
// - Enable bit gates trigger buffer and divider.
// - Calibration starts when PLL reset released.
// - Done reads one when finished or skipped.
module pco_device
	import pco_pkg::*;
#(
	parameter int SETTLE_CYC = PCO_CAL_SETTLE_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	pco_link_if.dev link,
	input wire logic pll_enable_pin,
	input wire logic ref_type_pin,
	input wire logic clock_config_pin_low,
	input wire logic clock_config_pin_high,
	input wire logic timestamp_input,
	input wire logic ser_ui_tick,
	input wire logic ser_reinit,
	input wire logic ref_tick,
	input wire logic vco_fast,
	output logic trigger_output_pins,
	output logic first_divided_ref_output,
	output logic second_divided_ref_output,
	output logic pll_enable,
	output logic single_ended_ref_input,
	output logic [6:0] oscillator_trim,
	output logic oscillator_cal_complete
);
	// ----------------------------------------------------------------
	// Helper functions.
	// ----------------------------------------------------------------
	// Half period in UI for a serializer-derived mode.
	function automatic logic [5:0] half_of(input logic [2:0] mode);
		logic [5:0] h;
		h = PCO_HALF_UI16;
		if (mode == PCO_TRIG_UI32) begin
			h = PCO_HALF_UI32;
		end else if (mode == PCO_TRIG_UI64) begin
			h = PCO_HALF_UI64;
		end
		return h;
	endfunction

	// Next level of a divided reference output; mode 0 holds it low.
	function automatic logic divref_next(input logic [1:0] mode, input logic cur,
			input logic [1:0] cnt, input logic tick);
		logic n;
		n = cur;
		if (mode == 2'h0) begin
			n = 1'b0;
		end else if (tick) begin
			if (mode == 2'h1 || (mode == 2'h2 && cnt[0]) || (mode == 2'h3 && cnt == 2'h3)) begin
				n = ~cur;
			end
		end
		return n;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers.
	// ----------------------------------------------------------------
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic pll_en_s;
	logic ref_se_s;
	logic cfg_lo_s;
	logic cfg_hi_s;
	logic ts_s;
	logic fast_s;

	// Only the second stage is read by logic.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
		end else begin
			sync1_r <= {vco_fast, timestamp_input, clock_config_pin_high,
				clock_config_pin_low, ref_type_pin, pll_enable_pin};
			sync2_r <= sync1_r;
		end
	end
	assign {fast_s, ts_s, cfg_hi_s, cfg_lo_s, ref_se_s, pll_en_s} = sync2_r;

	// ----------------------------------------------------------------
	// Register file.
	// ----------------------------------------------------------------
	logic [7:0] trig_r;
	logic [7:0] ovr_r;
	logic [6:0] trim_r;
	logic prst_r;
	logic cal_en_r;
	logic done_r;
	logic [7:0] rdata_r;
	pco_cal_state_t cal_r;
	logic [2:0] bit_r;
	logic [15:0] settle_r;
	logic wr_trig;
	logic wr_ovr;
	logic wr_prst;

	assign wr_trig = link.wr && link.addr == PCO_ADDR_TRIG;
	assign wr_ovr = link.wr && link.addr == PCO_ADDR_OVR;
	assign wr_prst = link.wr && link.addr == PCO_ADDR_PRST;

	// Reserved bits are never stored, so they always read back as zero.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			trig_r <= PCO_RST_TRIG;
			ovr_r <= PCO_RST_OVR;
			prst_r <= 1'b0;
			cal_en_r <= 1'b0;
		end else begin
			if (wr_trig) begin
				trig_r <= link.wdata & PCO_MASK_TRIG;
			end
			// Fields are stored in either mode and apply once override is set.
			if (wr_ovr) begin
				ovr_r <= link.wdata & PCO_MASK_OVR;
			end
			if (wr_prst) begin
				prst_r <= link.wdata[0];
			end
			if (link.wr && link.addr == PCO_ADDR_CAL) begin
				cal_en_r <= link.wdata[0];
			end
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 8'h00;
		end else if (link.rd) begin
			unique case (link.addr)
				PCO_ADDR_TRIG: rdata_r <= trig_r;
				PCO_ADDR_OVR: rdata_r <= ovr_r;
				PCO_ADDR_TRIM: rdata_r <= {1'b0, trim_r};
				PCO_ADDR_PRST: rdata_r <= {7'h00, prst_r};
				PCO_ADDR_CAL: rdata_r <= {7'h00, cal_en_r};
				PCO_ADDR_STAT: rdata_r <= {7'h00, done_r};
				default: rdata_r <= 8'h00;
			endcase
		end
	end
	assign link.rdata = rdata_r;

	// ----------------------------------------------------------------
	// Oscillator calibration engine.
	// ----------------------------------------------------------------
	// Successive approximation from the top bit: each step sets a bit,
	// lets the loop settle, then drops the bit if the oscillator is fast.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cal_r <= PCO_CAL_IDLE;
			trim_r <= PCO_RST_TRIM;
			bit_r <= 3'h0;
			settle_r <= 16'h0000;
			done_r <= 1'b0;
		end else begin
			if (link.wr && link.addr == PCO_ADDR_TRIM) begin
				trim_r <= link.wdata[6:0];
			end
			if (wr_prst && link.wdata[0]) begin
				cal_r <= PCO_CAL_IDLE; // Holding the PLL in reset aborts calibration.
				done_r <= 1'b0;
			end else if (wr_prst && prst_r) begin
				if (cal_en_r) begin
					cal_r <= PCO_CAL_SETTLE;
					trim_r <= 7'h40;
					bit_r <= 3'h6;
					settle_r <= 16'(SETTLE_CYC);
					done_r <= 1'b0;
				end else begin
					cal_r <= PCO_CAL_DONE;
					done_r <= 1'b1;
				end
			end else begin
				unique case (cal_r)
					PCO_CAL_IDLE: cal_r <= PCO_CAL_IDLE;
					PCO_CAL_SETTLE: begin
						settle_r <= settle_r - 16'h0001;
						if (settle_r <= 16'h0001) begin
							cal_r <= PCO_CAL_DECIDE;
						end
					end
					PCO_CAL_DECIDE: begin
						trim_r[bit_r] <= ~fast_s;
						if (bit_r == 3'h0) begin
							cal_r <= PCO_CAL_DONE;
							done_r <= 1'b1;
						end else begin
							trim_r[bit_r - 3'h1] <= 1'b1;
							bit_r <= bit_r - 3'h1;
							settle_r <= 16'(SETTLE_CYC);
							cal_r <= PCO_CAL_SETTLE;
						end
					end
					PCO_CAL_DONE: cal_r <= PCO_CAL_DONE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// PLL control selection.
	// ----------------------------------------------------------------
	logic ovr_on;
	logic [1:0] first_mode;
	logic [1:0] second_mode;
	logic [1:0] first_pin_mode;
	logic [1:0] second_pin_mode;

	assign ovr_on = ovr_r[PCO_OVR_EN_BIT];
	// Pin decode of the two clock configuration pins.
	assign first_pin_mode = {cfg_hi_s & cfg_lo_s, cfg_hi_s ^ cfg_lo_s};
	assign second_pin_mode = cfg_hi_s ? {1'b1, cfg_lo_s} : 2'h0;
	// Override off ignores the fields and follows the pins.
	assign first_mode = ovr_on ? ovr_r[3:2] : first_pin_mode;
	assign second_mode = ovr_on ? ovr_r[5:4] : second_pin_mode;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pll_enable <= 1'b0;
			single_ended_ref_input <= 1'b0;
		end else begin
			pll_enable <= ovr_on ? ovr_r[PCO_OVR_PLLEN_BIT] : pll_en_s;
			single_ended_ref_input <= ovr_on ? ovr_r[PCO_OVR_REFSE_BIT] : ref_se_s;
		end
	end

	// ----------------------------------------------------------------
	// Divided reference outputs.
	// ----------------------------------------------------------------
	logic [1:0] ref_cnt_r;

	// A shared counter keeps the two outputs phase aligned.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ref_cnt_r <= 2'h0;
			first_divided_ref_output <= 1'b0;
			second_divided_ref_output <= 1'b0;
		end else begin
			if (ref_tick) begin
				ref_cnt_r <= ref_cnt_r + 2'h1;
			end
			first_divided_ref_output <= divref_next(first_mode, first_divided_ref_output,
				ref_cnt_r, ref_tick);
			// The second output stays low whenever the first is off.
			second_divided_ref_output <= divref_next(first_mode == 2'h0 ? 2'h0 : second_mode,
				second_divided_ref_output, ref_cnt_r, ref_tick);
		end
	end

	// ----------------------------------------------------------------
	// Trigger output.
	// ----------------------------------------------------------------
	logic [5:0] ui_cnt_r;
	logic [2:0] tmode;
	logic trig_on;

	assign tmode = trig_r[2:0];
	assign trig_on = trig_r[PCO_TRIG_EN_BIT];

	// Mode is assumed stable while enabled; a change with the output on may glitch.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ui_cnt_r <= 6'h00;
			trigger_output_pins <= 1'b0;
		end else if (!trig_on) begin
			ui_cnt_r <= 6'h00;
			trigger_output_pins <= 1'b0;
		end else if (tmode == PCO_TRIG_TSTAMP) begin
			trigger_output_pins <= ts_s;
		end else if (tmode > PCO_TRIG_TSTAMP) begin
			trigger_output_pins <= 1'b0;
		end else if (ser_reinit) begin
			ui_cnt_r <= 6'h00;
			trigger_output_pins <= 1'b0;
		end else if (ser_ui_tick) begin
			if (ui_cnt_r == half_of(tmode) - 6'h01) begin
				ui_cnt_r <= 6'h00;
				trigger_output_pins <= ~trigger_output_pins;
			end else begin
				ui_cnt_r <= ui_cnt_r + 6'h01;
			end
		end
	end

	assign oscillator_trim = trim_r;
	assign oscillator_cal_complete = done_r;
endmodule

// ### hw/pco_host.sv
`timescale 1ns/1ps
module pco_host
	import pco_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	pco_link_if.host link,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [7:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic cmd_refused,
	output logic cal_busy
);
	// ----------------------------------------------------------------
	// Command checking.
	// ----------------------------------------------------------------
	// Reserved-bit mask for a register address.
	function automatic logic [7:0] mask_of(input logic [7:0] a);
		logic [7:0] m;
		unique case (a)
			PCO_ADDR_TRIG: m = PCO_MASK_TRIG;
			PCO_ADDR_OVR: m = PCO_MASK_OVR;
			PCO_ADDR_TRIM: m = PCO_MASK_TRIM;
			PCO_ADDR_PRST: m = PCO_MASK_PRST;
			PCO_ADDR_CAL: m = PCO_MASK_CAL;
			default: m = 8'hFF;
		endcase
		return m;
	endfunction

	logic [7:0] trig_sh_r;
	logic cal_en_sh_r;
	logic busy_r;
	logic stat_pend_r;
	logic rd_pend_r;
	logic trim_block;
	logic mode_block;
	logic refuse;

	// Trim access is held off while a calibration may be running.
	assign trim_block = cmd_addr == PCO_ADDR_TRIM && busy_r;
	// A mode change is only allowed while the trigger output is disabled.
	assign mode_block = cmd_wr && cmd_addr == PCO_ADDR_TRIG && trig_sh_r[PCO_TRIG_EN_BIT]
		&& cmd_wdata[2:0] != trig_sh_r[2:0];
	assign refuse = (cmd_wr || cmd_rd) && (trim_block || mode_block);

	// Shadows of what the device holds, kept from our own writes.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			trig_sh_r <= PCO_RST_TRIG;
			cal_en_sh_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			if (cmd_wr && !refuse && cmd_addr == PCO_ADDR_TRIG) begin
				trig_sh_r <= cmd_wdata & PCO_MASK_TRIG;
			end
			if (cmd_wr && cmd_addr == PCO_ADDR_CAL) begin
				cal_en_sh_r <= cmd_wdata[0];
			end
			// Releasing the PLL reset with calibration on marks it busy.
			if (cmd_wr && cmd_addr == PCO_ADDR_PRST) begin
				busy_r <= cal_en_sh_r && !cmd_wdata[0];
			end else if (stat_pend_r && link.rdata[0]) begin
				busy_r <= 1'b0; // A status read showing done ends the hold-off.
			end
		end
	end

	// ----------------------------------------------------------------
	// Link drive and read return.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link.addr <= 8'h00;
			link.wdata <= 8'h00;
			link.wr <= 1'b0;
			link.rd <= 1'b0;
			cmd_refused <= 1'b0;
		end else begin
			link.addr <= cmd_addr;
			link.wdata <= cmd_wdata & mask_of(cmd_addr);
			link.wr <= cmd_wr && !refuse;
			link.rd <= cmd_rd && !refuse;
			cmd_refused <= refuse;
		end
	end

	// Device data stand one cycle after the link strobe; capture them then.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_pend_r <= 1'b0;
			stat_pend_r <= 1'b0;
			cmd_rdata <= 8'h00;
			cmd_rvalid <= 1'b0;
			cal_busy <= 1'b0;
		end else begin
			rd_pend_r <= link.rd;
			stat_pend_r <= link.rd && link.addr == PCO_ADDR_STAT;
			cmd_rvalid <= rd_pend_r;
			cal_busy <= busy_r;
			if (rd_pend_r) begin
				cmd_rdata <= link.rdata; // Saved trim can be written back later.
			end
		end
	end
endmodule

// ### test/pco_checker.sv
`timescale 1ns/1ps
module pco_checker
	import pco_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Shadows of what the host told the device
	// ----------------------------------------
	logic [7:0] trig_r;
	logic prst_r;
	logic cal_en_r;
	logic run_r;
	logic skip_r;
	logic stat_rd_r;
	// Control shadows follow link writes only, as the device itself does.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			trig_r <= 8'h00;
			prst_r <= 1'b0;
			cal_en_r <= 1'b0;
		end else if (wr) begin
			trig_r <= (addr == PCO_ADDR_TRIG) ? wdata : trig_r;
			prst_r <= (addr == PCO_ADDR_PRST) ? wdata[0] : prst_r;
			cal_en_r <= (addr == PCO_ADDR_CAL) ? wdata[0] : cal_en_r;
		end
	end
	// Busy ends on a done readback or on the next PLL reset write, so the checker never clears it early.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			run_r <= 1'b0;
			skip_r <= 1'b0;
			stat_rd_r <= 1'b0;
		end else begin
			stat_rd_r <= rd && addr == PCO_ADDR_STAT;
			if (wr && addr == PCO_ADDR_PRST) begin
				run_r <= !wdata[0] && prst_r && cal_en_r;
				skip_r <= !wdata[0] && prst_r && !cal_en_r;
			end else if (stat_rd_r && rdata[0]) begin
				run_r <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Sequences and assertions
	// ----------------------------------------
	sequence trim_wr_s;
		wr && addr == PCO_ADDR_TRIM;
	endsequence
	sequence trim_rd_s;
		rd && addr == PCO_ADDR_TRIM;
	endsequence
	sequence trig_wr_rd_s;
		(wr && addr == PCO_ADDR_TRIG) ##1 (rd && addr == PCO_ADDR_TRIG);
	endsequence
	chk_trim_readback: assert property (
		trim_wr_s ##1 trim_rd_s |=> rdata == ($past(wdata, 2) & PCO_MASK_TRIM))
		else $error("trim readback differs from written value");
	chk_trig_readback: assert property (
		trig_wr_rd_s |=> rdata == ($past(wdata, 2) & PCO_MASK_TRIG))
		else $error("trigger control readback differs");
	chk_trim_top_zero: assert property (
		trim_rd_s |=> !rdata[7])
		else $error("trim reserved bit read as one");
	chk_ovr_res_write: assert property (
		wr && addr == PCO_ADDR_OVR |-> !wdata[6])
		else $error("override reserved bit written as one");
	chk_trim_res_write: assert property (
		trim_wr_s |-> !wdata[7])
		else $error("trim reserved bit written as one");
	chk_mode_locked: assert property (
		wr && addr == PCO_ADDR_TRIG && trig_r[7] |-> wdata[2:0] == trig_r[2:0])
		else $error("trigger mode changed while output enabled");
	chk_trim_quiet: assert property (
		run_r |-> !((wr || rd) && addr == PCO_ADDR_TRIM))
		else $error("trim touched during calibration");
	chk_skip_done: assert property (
		rd && addr == PCO_ADDR_STAT && skip_r && $past(skip_r, 2) |=> rdata[0])
		else $error("skipped calibration not reported done");
	chk_stat_res_zero: assert property (
		rd && addr == PCO_ADDR_STAT |=> rdata[7:1] == 7'h00)
		else $error("status reserved bits not zero");
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import pco_pkg::*;
;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [3:0] pins;
		logic [1:0] sel;
		logic [7:0] hp;
	} pco_row_t;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic pll_pin = 1'b0, ref_pin = 1'b0, cfg_h = 1'b0, cfg_l = 1'b0;
	logic tstamp = 1'b0, reinit = 1'b0, vco_fast = 1'b0;
	logic [1:0] tcnt = 2'h0;
	logic [7:0] cmd_rdata, rq, ovr;
	logic cmd_rvalid, cmd_refused, rf, trig_out, first_out, second_out, pll_enable, se_ref;
	logic cal_complete, cal_busy;
	logic [6:0] trim;
	int mismatches = 0;
	int checked = 0;
	// Register, data, pins {pll, ref, cfg high, cfg low}, output, half period.
	pco_row_t rows [19] = '{
		'{8'h58, 8'h85, 4'h0, 2'h1, 8'h04}, '{8'h58, 8'h8A, 4'hC, 2'h1, 8'h08},
		'{8'h58, 8'h8F, 4'h0, 2'h1, 8'h10}, '{8'h58, 8'h9C, 4'h0, 2'h2, 8'h04},
		'{8'h58, 8'hAC, 4'h0, 2'h2, 8'h08}, '{8'h58, 8'hBC, 4'h0, 2'h2, 8'h10},
		'{8'h58, 8'hB0, 4'h0, 2'h2, 8'h00}, '{8'h58, 8'h80, 4'h0, 2'h1, 8'h00},
		'{8'h58, 8'h3C, 4'hD, 2'h1, 8'h04}, '{8'h58, 8'h3C, 4'h6, 2'h2, 8'h08},
		'{8'h58, 8'h3C, 4'h3, 2'h2, 8'h10}, '{8'h58, 8'h3C, 4'h0, 2'h1, 8'h00},
		'{8'h57, 8'h80, 4'h0, 2'h0, 8'h10}, '{8'h57, 8'h00, 4'h0, 2'h0, 8'h00},
		'{8'h57, 8'h01, 4'h0, 2'h0, 8'h00}, '{8'h57, 8'h81, 4'h0, 2'h0, 8'h20},
		'{8'h57, 8'h01, 4'h0, 2'h0, 8'h00}, '{8'h57, 8'h02, 4'h0, 2'h0, 8'h00},
		'{8'h57, 8'h82, 4'h0, 2'h0, 8'h40}};
	// ----------------------------------------
	// Clock, ticks and the two ends
	// ----------------------------------------
	initial begin
		forever #4 mclk = ~mclk;
	end
	// One UI every second cycle and one reference half period every fourth.
	always @(posedge mclk) begin
		tcnt <= tcnt + 2'h1;
	end
	pco_link_if link (.mclk(mclk));
	pco_device #(.SETTLE_CYC(3)) u_pco_device (.mclk(mclk), .rst_b(rst_b), .link(link),
		.pll_enable_pin(pll_pin), .ref_type_pin(ref_pin), .clock_config_pin_low(cfg_l),
		.clock_config_pin_high(cfg_h), .timestamp_input(tstamp), .ser_ui_tick(tcnt[0]),
		.ser_reinit(reinit), .ref_tick(&tcnt), .vco_fast(vco_fast),
		.trigger_output_pins(trig_out), .first_divided_ref_output(first_out),
		.second_divided_ref_output(second_out), .pll_enable(pll_enable),
		.single_ended_ref_input(se_ref), .oscillator_trim(trim),
		.oscillator_cal_complete(cal_complete));
	pco_host u_pco_host (.mclk(mclk), .rst_b(rst_b), .link(link), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
		.cmd_rvalid(cmd_rvalid), .cmd_refused(cmd_refused), .cal_busy(cal_busy));
	pco_checker u_pco_checker (.mclk(mclk), .rst_b(rst_b), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Write, read, or a write followed at once by a read of the same place.
	task automatic xfer(input logic do_wr, input logic do_rd, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic refused);
		q = 8'h00;
		@(posedge mclk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= do_wr;
		cmd_rd <= !do_wr;
		@(posedge mclk);
		cmd_wr <= 1'b0;
		cmd_rd <= do_wr & do_rd;
		#1 refused = cmd_refused;
		if (do_rd) begin
			if (do_wr) begin
				@(posedge mclk);
				cmd_rd <= 1'b0;
				#1;
			end
			for (int i = 0; i < 6 && cmd_rvalid !== 1'b1; i++) begin
				refused = refused | cmd_refused;
				@(posedge mclk);
				#1;
			end
			q = cmd_rdata;
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, 1'b0, a, d, rq, rf);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
		xfer(1'b0, 1'b1, a, 8'h00, rq, rf);
		check(what, e, rq);
	endtask
	function automatic logic pick(input logic [1:0] s);
		return (s == 2'h0) ? trig_out : ((s == 2'h1) ? first_out : second_out);
	endfunction
	// Cycles between two toggles of one output; zero when it stands still.
	task automatic measure(input logic [1:0] s, output logic [7:0] hp);
		logic v;
		int n;
		hp = 8'h00;
		for (int k = 0; k < 2; k++) begin
			v = pick(s);
			for (n = 0; n < 100 && pick(s) === v; n++) begin
				@(posedge mclk);
				#1;
			end
		end
		if (n < 100) hp = 8'(n);
	endtask
	task automatic ts(input logic v, input logic e);
		@(posedge mclk);
		tstamp <= v;
		repeat (6) @(posedge mclk);
		#1 check("trig_out", {7'h00, e}, {7'h00, trig_out});
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		ovr = 8'h00;
		foreach (rows[i]) begin
			@(posedge mclk);
			{pll_pin, ref_pin, cfg_h, cfg_l} <= rows[i].pins;
			w(rows[i].a, rows[i].d);
			ovr = (rows[i].a == PCO_ADDR_OVR) ? rows[i].d : ovr;
			repeat (8) @(posedge mclk);
			#1 check("pll_en", {7'h00, ovr[7] ? ovr[0] : rows[i].pins[3]}, {7'h00, pll_enable});
			check("se_ref", {7'h00, ovr[7] ? ovr[1] : rows[i].pins[2]}, {7'h00, se_ref});
			measure(rows[i].sel, rq);
			check("half_period", rows[i].hp, rq);
		end
		$display("table test done");
		xfer(1'b1, 1'b1, PCO_ADDR_TRIM, 8'hAA, rq, rf);
		check("trim", 8'h2A, rq);
		check("trim_out", 8'h2A, {1'b0, trim});
		xfer(1'b1, 1'b1, PCO_ADDR_OVR, 8'hFF, rq, rf);
		check("ovr", 8'hBF, rq);
		rc(8'h00, 8'h00, "unmapped");
		w(PCO_ADDR_TRIG, 8'h83);
		check("refused", 8'h01, {7'h00, rf});
		w(PCO_ADDR_TRIG, 8'h02);
		w(PCO_ADDR_TRIG, 8'h03);
		xfer(1'b1, 1'b1, PCO_ADDR_TRIG, 8'h83, rq, rf);
		check("trig", 8'h83, rq);
		ts(1'b1, 1'b1);
		ts(1'b0, 1'b0);
		w(PCO_ADDR_TRIG, 8'h03);
		w(PCO_ADDR_TRIG, 8'h04);
		w(PCO_ADDR_TRIG, 8'h84);
		ts(1'b1, 1'b0);
		ts(1'b0, 1'b0);
		$display("register and timestamp test done");
		// The output is still on in mode 4, so it is switched off before the mode moves.
		w(PCO_ADDR_TRIG, 8'h04);
		w(PCO_ADDR_TRIG, 8'h00);
		w(PCO_ADDR_TRIG, 8'h80);
		@(posedge mclk);
		reinit <= 1'b1;
		repeat (4) @(posedge mclk);
		#1 check("reinit_out", 8'h00, {7'h00, trig_out});
		repeat (40) @(posedge mclk);
		#1 check("reinit_out", 8'h00, {7'h00, trig_out});
		@(posedge mclk);
		reinit <= 1'b0;
		measure(2'h0, rq);
		check("restart", 8'h10, rq);
		$display("reinit test done");
		w(PCO_ADDR_CAL, 8'h00);
		w(PCO_ADDR_PRST, 8'h01);
		w(PCO_ADDR_PRST, 8'h00);
		rc(PCO_ADDR_STAT, 8'h01, "done_skip");
		w(PCO_ADDR_PRST, 8'h01);
		rc(PCO_ADDR_STAT, 8'h00, "done_clear");
		w(PCO_ADDR_CAL, 8'h01);
		w(PCO_ADDR_PRST, 8'h00);
		xfer(1'b0, 1'b1, PCO_ADDR_TRIM, 8'h00, rq, rf);
		check("trim_busy", 8'h01, {7'h00, rf});
		check("cal_busy", 8'h01, {7'h00, cal_busy});
		rq = 8'h00;
		for (int n = 0; n < 20 && rq[0] !== 1'b1; n++) xfer(1'b0, 1'b1, PCO_ADDR_STAT, 8'h00, rq, rf);
		check("done_cal", 8'h01, rq);
		check("done_out", 8'h01, {7'h00, cal_complete});
		rc(PCO_ADDR_TRIM, 8'h7F, "trim_cal");
		check("cal_idle", 8'h00, {7'h00, cal_busy});
		$display("calibration test done");
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		rc(PCO_ADDR_OVR, 8'h00, "ovr_reset");
		rc(PCO_ADDR_TRIG, 8'h00, "trig_reset");
		rc(PCO_ADDR_TRIM, 8'h00, "trim_reset");
		$display("reset test done");
		stop_test();
	end
	// Watchdog: the whole run needs well under 20000 cycles.
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		stop_test();
	end
endmodule
